// ### srb_pkg.sv
// Shared constants and types of the special register bank
package srb_pkg;
  localparam int DW = 8;
  localparam int AW = 12;
  localparam int RAM_AW = 9;
  localparam int P7W = 6;
  // ---------------------------------------------------------------
  // Data memory addresses
  // ---------------------------------------------------------------
  localparam logic [5:0] A_INDIRECT = 6'h00;
  localparam logic [5:0] A_STATUS = 6'h03;
  localparam logic [5:0] A_MEMSEL = 6'h04;
  localparam logic [5:0] A_PORT5 = 6'h05;
  localparam logic [5:0] A_PORT6 = 6'h06;
  localparam logic [5:0] A_PORT7 = 6'h07;
  localparam logic [5:0] A_AIN = 6'h08;
  localparam logic [5:0] A_CONV = 6'h09;
  localparam logic [5:0] A_BANK_LO = 6'h05;
  localparam logic [5:0] A_BANK_HI = 6'h0f;
  localparam logic [5:0] A_GEN_LO = 6'h10;
  localparam logic [5:0] A_GEN_HI = 6'h1f;
  // ---------------------------------------------------------------
  // Bus word indices beyond the data memory
  // ---------------------------------------------------------------
  localparam logic [6:0] IX_DATA_END = 7'h40;
  localparam logic [6:0] IX_CTRL_LO = 7'h45;
  localparam logic [6:0] IX_CTRL_HI = 7'h4f;
  localparam logic [6:0] IX_CONV_STATUS = 7'h50;
  // ---------------------------------------------------------------
  // Backing memory regions
  // ---------------------------------------------------------------
  localparam logic [3:0] RAM_COMMON = 4'h0;
  localparam logic [2:0] RAM_CTRL = 3'h1;
  localparam logic [0:0] RAM_BANK = 1'h1;
  // ---------------------------------------------------------------
  // Reset values and pin positions
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam int P5_VREF_BIT = 3;
  localparam int P6_CMP_BIT = 0;
  localparam int DONE_CLR_BIT = 0;
  // ---------------------------------------------------------------
  // Converter timing
  // ---------------------------------------------------------------
  localparam logic [6:0] DIV4 = 7'h04;
  localparam logic [6:0] DIV8 = 7'h08;
  localparam logic [6:0] DIV16 = 7'h10;
  localparam logic [6:0] DIV64 = 7'h40;
  localparam logic [3:0] CONV_TICKS = 4'hc;
  localparam int ADC_W = 12;

  typedef enum logic [1:0] {
    CK_DIV16 = 2'h0,
    CK_DIV4 = 2'h1,
    CK_DIV64 = 2'h2,
    CK_DIV8 = 2'h3
  } srb_clk_div_t;

  typedef struct packed {
    logic ctrl_segment_select;
    logic [1:0] fixed_zero;
    logic timeout;
    logic power_down;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } srb_status_t;

  typedef struct packed {
    logic [1:0] bank;
    logic [5:0] pointer;
  } srb_memsel_t;

  typedef struct packed {
    logic reference_source_select;
    srb_clk_div_t conversion_clock_divider;
    logic conversion_running;
    logic converter_power_on;
    logic [2:0] analog_channel_select;
  } srb_conv_ctrl_t;
endpackage

// ### srb_ram.sv
// Byte memory for common, banked and control segment registers
module srb_ram
  import srb_pkg::*;
(
  input wire logic pclk,
  input wire logic we,
  input wire logic [RAM_AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [RAM_AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<RAM_AW)-1];

  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### srb_conv.sv
// Conversion sequencer: clock prescaler and conversion length
module srb_conv
  import srb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire srb_clk_div_t clk_sel,
  output logic done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } srb_conv_state_t;

  localparam int MAX_WAIT = 800;

  srb_conv_state_t state;
  srb_clk_div_t sel;
  logic [6:0] presc;
  logic [3:0] ticks;

  // Divider code 11 taken as oscillator/8
  function automatic logic [6:0] div_limit(input srb_clk_div_t s);
    case (s)
      CK_DIV4: div_limit = DIV4;
      CK_DIV8: div_limit = DIV8;
      CK_DIV64: div_limit = DIV64;
      default: div_limit = DIV16;
    endcase
  endfunction

  wire tick = presc == div_limit(sel) - 7'h01; // R17 R18
  wire last = ticks == CONV_TICKS - 4'h1;
  assign done = state == ST_DONE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      sel <= CK_DIV16;
      presc <= 7'h00;
      ticks <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          presc <= 7'h00;
          ticks <= 4'h0;
          sel <= clk_sel;
          if (start)
          begin
            state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          presc <= tick ? 7'h00 : presc + 7'h01;
          if (tick)
          begin
            ticks <= ticks + 4'h1;
            if (last)
            begin
              state <= ST_DONE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_conv_ends;
    start && state == ST_IDLE |-> ##[1:MAX_WAIT] done;
  endproperty
  a_conv_ends: assert property (p_conv_ends) // R17
    else $error("conversion did not finish in time");

  property p_done_once;
    done |=> !done;
  endproperty
  a_done_once: assert property (p_done_once) // R23
    else $error("done held more than one cycle");
endmodule

// ### srb_bank.sv
// Special register bank with converter control, APB slave
//
// Summary of operation
// R1: Status bit 7 picks control segment.
// R2: Status bits 6 and 5 read zero.
// R3: Timeout set by reset/sleep/clear, cleared by timeout.
// R4: Power-down set by reset/clear, cleared by sleep.
// R5: Software writes never change timeout or power-down.
// R6: Zero, half carry, carry follow the ALU.
// R7: Memory select bits 7:6 pick bank.
// R8: Memory select bits 5:0 hold indirect address.
// R9: Address 00 redirects through memory select.
// R10: Common and banked ranges; segment for control.
// R11: Third port has six bits, top zero.
// R12: Analog enable bit n frees port six pin.
// R13: Comparator over analog over digital on pin zero.
// R14: Bit 7 selects pin reference, else supply.
// R15: Reference over third PWM over digital I/O.
// R16: Software keeps PWM off when pin is reference.
// R17: Bits 6:5 select conversion clock divider.
// R18: Divider code 11 means oscillator/8.
// R19: Writing 1 starts; hardware alone clears run.
// R20: Bit 3 low powers the converter reference down.
// R21: Bits 2:0 select analog input zero to seven.
// R22: Channel changes only when idle and flag clear.
// R23: Completion loads result, clears run, sets flag.
//
// The implementer's own choice: the APB register port.
module srb_bank
  import srb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alu_flag_update,
  input wire logic alu_zero,
  input wire logic alu_half_carry,
  input wire logic alu_carry,
  input wire logic sleep_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic watchdog_timeout,
  input wire logic third_pwm_output_enable,
  input wire logic third_pwm_wave,
  input wire logic comparator_output_enable,
  input wire logic comparator_output,
  input wire logic [DW-1:0] port_five_in,
  output logic [DW-1:0] port_five_out,
  output logic [DW-1:0] port_five_oe,
  input wire logic [DW-1:0] port_six_in,
  output logic [DW-1:0] port_six_out,
  output logic [DW-1:0] port_six_oe,
  input wire logic [P7W-1:0] port_seven_in,
  output logic [P7W-1:0] port_seven_out,
  output logic [P7W-1:0] port_seven_oe,
  input wire logic [ADC_W-1:0] analog_sample,
  output logic [ADC_W-1:0] conversion_result,
  output logic conversion_done_flag,
  output logic conversion_running,
  output logic [2:0] analog_channel,
  output logic reference_from_pin,
  output logic converter_power_on,
  output logic ctrl_segment_select
);
  localparam int PW = 2 * DW + P7W;

  srb_status_t status_flags;
  srb_memsel_t memory_select;
  srb_conv_ctrl_t converter_control;
  srb_status_t next_status;
  srb_conv_ctrl_t next_conv;
  logic [DW-1:0] port_five_data;
  logic [DW-1:0] port_six_data;
  logic [P7W-1:0] port_seven_data;
  logic [DW-1:0] dir_five;
  logic [DW-1:0] dir_six;
  logic [P7W-1:0] dir_seven;
  logic [DW-1:0] analog_input_enable;
  logic ack;
  logic conv_done;
  logic [DW-1:0] ram_q;
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic [PW-1:0] pin_s3;
  logic [PW-1:0] pin_f;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic is_common(input logic [5:0] a);
    is_common = a < A_BANK_LO || (a >= A_GEN_LO && a <= A_GEN_HI);
  endfunction

  wire [6:0] idx = paddr[8:2];
  wire idx_ok = paddr[AW-1:9] == '0;
  wire access = psel && penable;
  wire ds = idx_ok && idx < IX_DATA_END;
  wire [5:0] reg6 = idx[5:0];
  wire indirect = reg6 == A_INDIRECT;
  wire [5:0] eff = indirect ? memory_select.pointer : reg6; // R8 R9
  wire hit_null = ds && eff == A_INDIRECT; // R9
  wire bank0 = memory_select.bank == 2'h0; // R7
  wire seg = status_flags.ctrl_segment_select;
  wire hit_status = ds && eff == A_STATUS;
  wire hit_memsel = ds && eff == A_MEMSEL;
  wire hit_p5 = ds && bank0 && eff == A_PORT5;
  wire hit_p6 = ds && bank0 && eff == A_PORT6;
  wire hit_p7 = ds && bank0 && eff == A_PORT7;
  wire hit_ain = ds && bank0 && eff == A_AIN;
  wire hit_conv = ds && bank0 && eff == A_CONV;
  wire hit_ctl = idx_ok && idx >= IX_CTRL_LO && idx <= IX_CTRL_HI;
  wire hit_d5 = hit_ctl && !seg && reg6 == A_PORT5; // R1
  wire hit_d6 = hit_ctl && !seg && reg6 == A_PORT6; // R1
  wire hit_d7 = hit_ctl && !seg && reg6 == A_PORT7; // R1
  wire hit_cst = idx_ok && idx == IX_CONV_STATUS;
  wire hit_real = hit_null || hit_status || hit_memsel || hit_p5
    || hit_p6 || hit_p7 || hit_ain || hit_conv || hit_d5 || hit_d6
    || hit_d7;
  wire hit_ram = (ds || hit_ctl) && !hit_real;
  wire bad = !(ds || hit_ctl || hit_cst);
  // R10
  wire [RAM_AW-1:0] ram_addr = hit_ctl ? {RAM_CTRL, seg, reg6[4:0]}
    : is_common(eff) ? {RAM_COMMON, eff[4:0]}
    : {RAM_BANK, memory_select.bank, eff};

  // ---------------------------------------------------------------
  // APB handshake, one wait state on every transfer
  // ---------------------------------------------------------------
  assign pready = access && ack;
  assign pslverr = pready && bad;
  wire wr_fire = pready && pwrite && !bad;
  wire [DW-1:0] wd = pwdata[DW-1:0];

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  wire [PW-1:0] pins_in = {port_seven_in, port_six_in, port_five_in};
  wire [PW-1:0] pins_agree = ~(pin_s2 ^ pin_s3);
  wire [DW-1:0] pin5 = pin_f[DW-1:0];
  wire [DW-1:0] pin6 = pin_f[2*DW-1:DW];
  wire [P7W-1:0] pin7 = pin_f[PW-1:2*DW];

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  wire [DW-1:0] rd_p5 = (dir_five & pin5) | (~dir_five & port_five_data);
  wire [DW-1:0] rd_p6 = ((dir_six & pin6) | (~dir_six & port_six_data))
    & ~analog_input_enable;
  wire [P7W-1:0] rd_p7 = (dir_seven & pin7)
    | (~dir_seven & port_seven_data);
  wire [DW-1:0] rd_mux = hit_status ? status_flags
    : hit_memsel ? memory_select
    : hit_p5 ? rd_p5
    : hit_p6 ? rd_p6
    : hit_p7 ? DW'(rd_p7) // R11
    : hit_ain ? analog_input_enable
    : hit_conv ? converter_control
    : hit_d5 ? dir_five
    : hit_d6 ? dir_six
    : hit_d7 ? DW'(dir_seven)
    : hit_cst ? DW'(conversion_done_flag)
    : hit_ram ? ram_q
    : REG_RST;

  // ---------------------------------------------------------------
  // Status and converter next values
  // ---------------------------------------------------------------
  wire conv_wr = wr_fire && hit_conv;
  wire srb_conv_ctrl_t conv_wd = srb_conv_ctrl_t'(wd);
  wire start = conv_wr && conv_wd.conversion_running
    && !converter_control.conversion_running; // R19
  wire chan_open = !conversion_done_flag
    && !converter_control.conversion_running; // R22
  wire done_clr = wr_fire && hit_cst && pwdata[DONE_CLR_BIT];

  always_comb
  begin
    next_status = status_flags;
    if (wr_fire && hit_status)
    begin
      next_status.ctrl_segment_select = wd[DW-1]; // R1
      next_status.zero = wd[2];
      next_status.half_carry_flag = wd[1];
      next_status.carry = wd[0];
    end
    if (alu_flag_update)
    begin
      next_status.zero = alu_zero; // R6
      next_status.half_carry_flag = alu_half_carry; // R6
      next_status.carry = alu_carry; // R6
    end
    if (watchdog_timeout)
    begin
      next_status.timeout = 1'b0; // R3
    end
    if (sleep_instruction)
    begin
      next_status.timeout = 1'b1; // R3
      next_status.power_down = 1'b0; // R4
    end
    if (watchdog_clear_instruction)
    begin
      next_status.timeout = 1'b1; // R3
      next_status.power_down = 1'b1; // R4
    end
    next_status.fixed_zero = 2'h0; // R2
  end

  always_comb
  begin
    next_conv = converter_control;
    if (conv_wr)
    begin
      next_conv.reference_source_select =
        conv_wd.reference_source_select; // R14
      next_conv.conversion_clock_divider =
        conv_wd.conversion_clock_divider; // R17
      next_conv.converter_power_on = conv_wd.converter_power_on; // R20
      if (chan_open)
      begin
        next_conv.analog_channel_select =
          conv_wd.analog_channel_select; // R21 R22
      end
    end
    if (conv_done)
    begin
      next_conv.conversion_running = 1'b0; // R23
    end
    if (start)
    begin
      next_conv.conversion_running = 1'b1; // R19
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack <= 1'b0;
      prdata <= '0;
      status_flags <= STATUS_RST; // R3 R4
      memory_select <= REG_RST;
      converter_control <= REG_RST;
      port_five_data <= REG_RST;
      port_six_data <= REG_RST;
      port_seven_data <= '0;
      dir_five <= DIR_RST;
      dir_six <= DIR_RST;
      dir_seven <= DIR_RST[P7W-1:0];
      analog_input_enable <= REG_RST;
      conversion_done_flag <= 1'b0;
      conversion_result <= '0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f <= '0;
    end
    else
    begin
      ack <= access && !ack;
      if (access && !ack)
      begin
        prdata <= {24'h000000, rd_mux};
      end
      status_flags <= next_status; // R5
      converter_control <= next_conv;
      if (wr_fire && hit_memsel)
      begin
        memory_select <= wd; // R7 R8
      end
      if (wr_fire && hit_p5)
      begin
        port_five_data <= wd;
      end
      if (wr_fire && hit_p6)
      begin
        port_six_data <= wd;
      end
      if (wr_fire && hit_p7)
      begin
        port_seven_data <= wd[P7W-1:0]; // R11
      end
      if (wr_fire && hit_d5)
      begin
        dir_five <= wd;
      end
      if (wr_fire && hit_d6)
      begin
        dir_six <= wd;
      end
      if (wr_fire && hit_d7)
      begin
        dir_seven <= wd[P7W-1:0];
      end
      if (wr_fire && hit_ain)
      begin
        analog_input_enable <= wd; // R12
      end
      if (conv_done)
      begin
        conversion_done_flag <= 1'b1; // R23
        conversion_result <= analog_sample; // R23
      end
      else if (done_clr)
      begin
        conversion_done_flag <= 1'b0;
      end
      pin_s1 <= pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pins_agree & pin_s2) | (~pins_agree & pin_f);
    end
  end

  srb_ram u_ram (
    .pclk(pclk),
    .we(wr_fire && hit_ram),
    .waddr(ram_addr),
    .wdata(wd),
    .raddr(ram_addr),
    .rdata(ram_q)
  );

  srb_conv u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .clk_sel(next_conv.conversion_clock_divider),
    .done(conv_done)
  );

  // ---------------------------------------------------------------
  // Pin function priority
  // ---------------------------------------------------------------
  wire p5_vref = converter_control.reference_source_select;
  wire p5_pwm = third_pwm_output_enable; // R16

  genvar i;
  generate
    for (i = 0; i < DW; i++)
    begin : g_p5
      if (i == P5_VREF_BIT)
      begin : g_shared
        // R15
        assign port_five_oe[i] = !p5_vref && (p5_pwm || !dir_five[i]);
        assign port_five_out[i] = p5_pwm ? third_pwm_wave
          : port_five_data[i];
      end
      else
      begin : g_plain
        assign port_five_oe[i] = !dir_five[i];
        assign port_five_out[i] = port_five_data[i];
      end
    end
    for (i = 0; i < DW; i++)
    begin : g_p6
      wire cmp = i == P6_CMP_BIT && comparator_output_enable;
      // R12 R13
      assign port_six_oe[i] = cmp
        || (!analog_input_enable[i] && !dir_six[i]);
      assign port_six_out[i] = cmp ? comparator_output
        : port_six_data[i];
    end
  endgenerate

  assign port_seven_oe = ~dir_seven;
  assign port_seven_out = port_seven_data;
  assign conversion_running = converter_control.conversion_running;
  assign analog_channel = converter_control.analog_channel_select;
  assign reference_from_pin = p5_vref; // R14
  assign converter_power_on = converter_control.converter_power_on;
  assign ctrl_segment_select = seg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_conv_write;
    wr_fire && hit_conv;
  endsequence

  property p_fixed_zero;
    status_flags.fixed_zero == 2'h0;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) // R2
    else $error("status bits 6:5 not zero");

  property p_sleep;
    sleep_instruction && !watchdog_clear_instruction
      |=> status_flags.timeout && !status_flags.power_down;
  endproperty
  a_sleep: assert property (p_sleep) // R3
    else $error("sleep did not set timeout and clear power-down");

  property p_wdt_clear;
    watchdog_clear_instruction
      |=> status_flags.timeout && status_flags.power_down;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) // R4
    else $error("watchdog clear did not set both flags");

  property p_timeout;
    watchdog_timeout && !sleep_instruction
      && !watchdog_clear_instruction |=> !status_flags.timeout;
  endproperty
  a_timeout: assert property (p_timeout) // R3
    else $error("watchdog timeout did not clear timeout flag");

  property p_read_only;
    !(sleep_instruction || watchdog_clear_instruction
      || watchdog_timeout)
      |=> $stable({status_flags.timeout, status_flags.power_down});
  endproperty
  a_read_only: assert property (p_read_only) // R5
    else $error("timeout or power-down changed without an event");

  property p_alu;
    alu_flag_update |=> status_flags.zero == $past(alu_zero)
      && status_flags.carry == $past(alu_carry);
  endproperty
  a_alu: assert property (p_alu) // R6
    else $error("ALU flags not captured");

  property p_start;
    s_conv_write ##0 (pwdata[4] && !conversion_running)
      |=> conversion_running [*2];
  endproperty
  a_start: assert property (p_start) // R19
    else $error("start write did not set run");

  property p_chan_locked;
    s_conv_write ##0 !chan_open |=> $stable(analog_channel);
  endproperty
  a_chan_locked: assert property (p_chan_locked) // R22
    else $error("channel changed while busy or flagged");

  property p_complete;
    conv_done |=> !conversion_running && conversion_done_flag
      && conversion_result == $past(analog_sample);
  endproperty
  a_complete: assert property (p_complete) // R23
    else $error("completion effects missing");

  property p_cmp_pin;
    comparator_output_enable |-> port_six_oe[P6_CMP_BIT]
      && port_six_out[P6_CMP_BIT] == comparator_output;
  endproperty
  a_cmp_pin: assert property (p_cmp_pin) // R13
    else $error("comparator does not own pin zero");

  property p_analog_pin;
    !comparator_output_enable |-> (port_six_oe & analog_input_enable)
      == '0;
  endproperty
  a_analog_pin: assert property (p_analog_pin) // R12
    else $error("analog pin driven");

  property p_vref_pin;
    p5_vref |-> !port_five_oe[P5_VREF_BIT];
  endproperty
  a_vref_pin: assert property (p_vref_pin) // R15
    else $error("reference pin driven");
endmodule

// ### srb_core.sv
// Core-side model: instruction event pulses and PWM drive
module srb_core
  import srb_pkg::*;
(
  input wire logic [2:0] ev,
  input wire logic pwm_req,
  input wire logic ref_pin,
  output logic sleep_ins,
  output logic wd_clear,
  output logic wd_timeout,
  output logic pwm_en
);
  // One-cycle instruction events
  assign sleep_ins = ev[0];
  assign wd_clear = ev[1];
  assign wd_timeout = ev[2];
  // PWM kept off while pin is the reference
  assign pwm_en = pwm_req & ~ref_pin;
endmodule

// ### special_register_bank_and_adc_control_tb.sv
// Testbench of the special register bank
module special_register_bank_and_adc_control_tb
  import srb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic alu_up, az, ah, ac, pwm_req, cmp_en, run, done, refp, pwr, css;
  logic slp, wdc, wdt, pwm_en;
  logic [2:0] ev, chan;
  logic [7:0] p5o, p5e, p6o, p6e;
  logic [5:0] p7o, p7e;
  logic [11:0] res, smp;
  int error_cnt, num_checks, n, dv[4];
  srb_core core (.ev(ev), .pwm_req(pwm_req), .ref_pin(refp),
    .sleep_ins(slp), .wd_clear(wdc), .wd_timeout(wdt), .pwm_en(pwm_en));
  srb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_flag_update(alu_up), .alu_zero(az), .alu_half_carry(ah),
    .alu_carry(ac), .sleep_instruction(slp),
    .watchdog_clear_instruction(wdc), .watchdog_timeout(wdt),
    .third_pwm_output_enable(pwm_en), .third_pwm_wave(1'b1),
    .comparator_output_enable(cmp_en), .comparator_output(1'b1),
    .port_five_in(8'h00), .port_five_out(p5o), .port_five_oe(p5e),
    .port_six_in(8'ha5), .port_six_out(p6o), .port_six_oe(p6e),
    .port_seven_in(6'h2d), .port_seven_out(p7o), .port_seven_oe(p7e),
    .analog_sample(smp), .conversion_result(res),
    .conversion_done_flag(done), .conversion_running(run),
    .analog_channel(chan), .reference_from_pin(refp),
    .converter_power_on(pwr), .ctrl_segment_select(css));
  initial
  begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // APB transfer; pready sampled at the rising edge that ends it
  task automatic apb(input logic w, input logic [6:0] ix, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {3'h0, ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    r[8] = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [6:0] ix, input logic [31:0] e);
    apb(0, ix, 8'h00);
    chk(r, e);
  endtask
  task automatic pulse(input logic [2:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 0;
    @(posedge pclk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #(50 * 20000);
    error_cnt++;
    final_report();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, alu_up, az, ah, ac} = 0;
    {pwm_req, cmp_en, ev, paddr, pwdata, smp} = 0;
    dv = '{16, 4, 64, 8};
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(7'h03, 32'h18);
    apb(1, 7'h03, 8'hff);
    rd(7'h03, 32'h9f);
    chk(css, 1);
    apb(1, 7'h03, 8'h00);
    rd(7'h03, 32'h18);
    pulse(3'b001);
    rd(7'h03, 32'h10);
    pulse(3'b100);
    rd(7'h03, 32'h00);
    pulse(3'b010);
    rd(7'h03, 32'h18);
    {alu_up, az, ah, ac} <= 4'hd;
    @(posedge pclk);
    alu_up <= 0;
    rd(7'h03, 32'h1d);
    $display("test status done");
    apb(1, 7'h04, 8'h40);
    apb(1, 7'h20, 8'ha5);
    apb(1, 7'h04, 8'h00);
    apb(1, 7'h20, 8'h5a);
    rd(7'h20, 32'h5a);
    apb(1, 7'h04, 8'h40);
    rd(7'h20, 32'ha5);
    apb(1, 7'h04, 8'h20);
    rd(7'h00, 32'h5a);
    apb(1, 7'h00, 8'h3c);
    rd(7'h20, 32'h3c);
    rd(7'h07, 32'h2d);
    rd(7'h44, 32'h100);
    apb(1, 7'h03, 8'h80);
    apb(1, 7'h47, 8'h55);
    apb(1, 7'h03, 8'h00);
    rd(7'h47, 32'h3f);
    apb(1, 7'h47, 8'h00);
    chk(p7e, 6'h3f);
    apb(1, 7'h07, 8'hff);
    rd(7'h07, 32'h3f);
    chk(p7o, 6'h3f);
    apb(1, 7'h03, 8'h80);
    rd(7'h47, 32'h55);
    apb(1, 7'h03, 8'h00);
    $display("test memory done");
    apb(1, 7'h08, 8'h0f);
    rd(7'h06, 32'ha0);
    cmp_en <= 1;
    pwm_req <= 1;
    @(posedge pclk);
    chk({p6e[0], p6o[0], p5e[3], p5o[3]}, 4'hf);
    apb(1, 7'h09, 8'h8b);
    chk({refp, pwr, chan}, 5'h1b);
    chk(p5e[3], 0);
    for (int k = 0; k < 4; k++)
    begin
      smp <= 12'h9c3 + 12'(k);
      apb(1, 7'h09, {1'b1, 2'(k), 5'h1b});
      apb(1, 7'h09, {1'b1, 2'(k), 5'h0d});
      chk({run, chan}, 4'hb);
      n = 0;
      while (done !== 1'b1 && n < 2000) @(posedge pclk) n++;
      chk(n > dv[k] * 12 - 12 && n < dv[k] * 12 + 6, 1);
      chk({run, res}, {1'b0, smp});
      apb(1, 7'h50, 8'h01);
    end
    $display("test converter done");
    final_report();
  end
endmodule
